// ---- rtl/rfcw_defines.svh ----
// constants for the relay filter control word block
// assumes core_clk at 40 MHz and one command word per load strobe
//
// Overview of operation
// - keep 32-bit word, upper and lower halves
// - clear at power-on, hold until first command
// - every bit active high, set energises relay
// - bit 27 high selects transmit
// - low-pass-only board uses bits 20 to 31
// - full boards map high-pass, preamp, attenuators
// - dual board band-pass bits in lower half
// - dual board low-pass bits in first word
// - dual bit 18 status, second word ground
// - lamps driven, bits 7 16 17 unconnected
`ifndef RFCW_DEFINES_SVH
`define RFCW_DEFINES_SVH

// ----------------------------------------------------------------
// word layout
// ----------------------------------------------------------------
`define RFCW_WORD_W 32
`define RFCW_RESET_WORD 32'h0000_0000
`define RFCW_TX_BIT 27
`define RFCW_STATUS_BIT 18
`define RFCW_SECOND_RECEIVER_INPUT_GROUND_BIT 8
`define RFCW_SHORTWAVE_BYPASS_BIT 12

// ----------------------------------------------------------------
// per-variant masks of connected bits
// ----------------------------------------------------------------
`define RFCW_MASK_FULL_PRI 32'hFFFC_FF7F
`define RFCW_MASK_LPF_PRI 32'hFFF0_0000
`define RFCW_MASK_DUAL_PRI 32'hFFFC_907F
`define RFCW_MASK_DUAL_SEC 32'h0000_917F
`define RFCW_MASK_NONE 32'h0000_0000

`endif

// ---- rtl/rfcw_pkg.sv ----
// types for the relay filter control word block
// assumes rfcw_defines.svh is included by the design file
package rfcw_pkg;

   // board flavour, strapped on pins
   typedef enum logic [1:0] {
      RFCW_FULL,
      RFCW_LPF_ONLY,
      RFCW_DUAL_SET,
      RFCW_SPARE
   } rfcw_variant_t;

   // which word a command loads
   typedef enum logic {
      RFCW_SEL_PRIMARY,
      RFCW_SEL_SECONDARY
   } rfcw_word_sel_t;

endpackage : rfcw_pkg

// ---- rtl/rfcw_relay_word.sv ----
// relay filter control word: two command-loaded words driving relays
// assumes command strobe comes from core_clk logic; variant straps are pins
`timescale 1ns/1ps
`include "rfcw_defines.svh"

module rfcw_relay_word (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic cmd_load,
   input wire rfcw_pkg::rfcw_word_sel_t cmd_select,
   input wire logic [31:0] cmd_word,
   input wire logic [1:0] variant_pins,
   output logic [31:0] relay_primary,
   output logic [31:0] relay_secondary,
   output logic transmit_select,
   output logic transmit_receive_status_bit,
   output logic second_receiver_input_ground,
   output logic command_seen
);
   import rfcw_pkg::*;

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   // connected bits of the first word for a board flavour
   function automatic logic [31:0] pri_mask(input rfcw_variant_t v);
      case (v)
         RFCW_FULL: pri_mask = `RFCW_MASK_FULL_PRI;
         RFCW_LPF_ONLY: pri_mask = `RFCW_MASK_LPF_PRI;
         RFCW_DUAL_SET: pri_mask = `RFCW_MASK_DUAL_PRI;
         default: pri_mask = `RFCW_MASK_NONE;
      endcase
   endfunction : pri_mask

   // connected bits of the second word, only the dual board has one
   function automatic logic [31:0] sec_mask(input rfcw_variant_t v);
      case (v)
         RFCW_DUAL_SET: sec_mask = `RFCW_MASK_DUAL_SEC;
         default: sec_mask = `RFCW_MASK_NONE;
      endcase
   endfunction : sec_mask

   // ----------------------------------------------------------------
   // strap synchroniser
   // ----------------------------------------------------------------
   logic [1:0] strap_meta_q;
   logic [1:0] strap_meta_d;
   logic [1:0] strap_sync_q;
   logic [1:0] strap_sync_d;
   rfcw_variant_t variant;

   // first stage feeds only the second stage
   always_comb begin
      strap_meta_d = variant_pins;
      strap_sync_d = strap_meta_q;
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         strap_meta_q <= 2'h0;
         strap_sync_q <= 2'h0;
      end else begin
         strap_meta_q <= strap_meta_d;
         strap_sync_q <= strap_sync_d;
      end
   end

   assign variant = rfcw_variant_t'(strap_sync_q);

   // ----------------------------------------------------------------
   // stored command words
   // ----------------------------------------------------------------
   logic [31:0] word_pri_q;
   logic [31:0] word_pri_d;
   logic [31:0] word_sec_q;
   logic [31:0] word_sec_d;
   logic seen_q;
   logic seen_d;

   // a whole word replaces the old one in a single edge
   always_comb begin
      word_pri_d = word_pri_q;
      word_sec_d = word_sec_q;
      seen_d = seen_q;
      if (cmd_load) begin
         seen_d = 1'b1;
         if (cmd_select == RFCW_SEL_PRIMARY) begin
            word_pri_d = cmd_word;
         end else begin
            word_sec_d = cmd_word;
         end
      end
   end

   // power-on value is all zero, kept until a command lands
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         word_pri_q <= `RFCW_RESET_WORD;
         word_sec_q <= `RFCW_RESET_WORD;
         seen_q <= 1'b0;
      end else begin
         word_pri_q <= word_pri_d;
         word_sec_q <= word_sec_d;
         seen_q <= seen_d;
      end
   end

   // ----------------------------------------------------------------
   // relay drive registers
   // ----------------------------------------------------------------
   logic [31:0] drive_pri_q;
   logic [31:0] drive_pri_d;
   logic [31:0] drive_sec_q;
   logic [31:0] drive_sec_d;
   logic tx_q;
   logic tx_d;
   logic status_q;
   logic status_d;
   logic ground_q;
   logic ground_d;

   // drive from the next word so all bits move on the same edge;
   // unconnected bits of both relay words are held low; transmit_select still takes bit 27 unmasked on every strap
   always_comb begin
      drive_pri_d = word_pri_d & pri_mask(variant);
      drive_sec_d = word_sec_d & sec_mask(variant);
      tx_d = word_pri_d[`RFCW_TX_BIT];
      status_d = (variant == RFCW_DUAL_SET) & word_pri_d[`RFCW_STATUS_BIT];
      ground_d = drive_sec_d[`RFCW_SECOND_RECEIVER_INPUT_GROUND_BIT];
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         drive_pri_q <= `RFCW_RESET_WORD;
         drive_sec_q <= `RFCW_RESET_WORD;
         tx_q <= 1'b0;
         status_q <= 1'b0;
         ground_q <= 1'b0;
      end else begin
         drive_pri_q <= drive_pri_d;
         drive_sec_q <= drive_sec_d;
         tx_q <= tx_d;
         status_q <= status_d;
         ground_q <= ground_d;
      end
   end

   // outputs straight from flops
   assign relay_primary = drive_pri_q;
   assign relay_secondary = drive_sec_q;
   assign transmit_select = tx_q;
   assign transmit_receive_status_bit = status_q;
   assign second_receiver_input_ground = ground_q;
   assign command_seen = seen_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // a primary load and a secondary load, each matched in one cycle
   sequence s_pri_load;
      cmd_load && cmd_select == RFCW_SEL_PRIMARY;
   endsequence

   sequence s_sec_load;
      cmd_load && cmd_select == RFCW_SEL_SECONDARY;
   endsequence

   a_idle_clear: assert property (@(posedge core_clk) disable iff (reset)
      !seen_q |-> relay_primary == 32'h0 && relay_secondary == 32'h0)
      else $error("relays energised before any command");

   a_load_primary: assert property (@(posedge core_clk) disable iff (reset)
      s_pri_load ##1 $stable(strap_sync_q)
      |-> relay_primary == ($past(cmd_word) & pri_mask(variant)))
      else $error("primary drive does not match loaded word");

   a_load_secondary: assert property (@(posedge core_clk) disable iff (reset)
      s_sec_load ##1 $stable(strap_sync_q)
      |-> relay_secondary == ($past(cmd_word) & sec_mask(variant)))
      else $error("secondary drive does not match loaded word");

   // the strap must be steady at the edge that feeds the drive, or the new mask moves it
   a_hold_quiet: assert property (@(posedge core_clk) disable iff (reset)
      !cmd_load && $stable(strap_sync_q) |=> $stable(relay_primary))
      else $error("primary drive moved without a command");

   // the second word stays put between its own loads
   a_hold_secondary: assert property (@(posedge core_clk) disable iff (reset)
      !(cmd_load && cmd_select == RFCW_SEL_SECONDARY) && $stable(strap_sync_q)
      |=> $stable(relay_secondary))
      else $error("secondary drive moved without a command");

   // status output is only meaningful on the dual board
   a_status_dual_only: assert property (@(posedge core_clk) disable iff (reset)
      variant != RFCW_DUAL_SET [*2] |-> transmit_receive_status_bit == 1'b0)
      else $error("status driven on a board without it");

   a_tx_follows: assert property (@(posedge core_clk) disable iff (reset)
      s_pri_load |=> transmit_select == $past(cmd_word[27]))
      else $error("changeover does not follow bit 27");

   a_lpf_only: assert property (@(posedge core_clk) disable iff (reset)
      variant == RFCW_LPF_ONLY [*2] |-> relay_primary[19:0] == 20'h0
      && relay_secondary == 32'h0)
      else $error("low-pass board drives lower bits");

   a_nc_bits: assert property (@(posedge core_clk) disable iff (reset)
      relay_primary[7] == 1'b0 && relay_primary[17:16] == 2'h0)
      else $error("unconnected bit driven");

   a_dual_status: assert property (@(posedge core_clk) disable iff (reset)
      variant == RFCW_DUAL_SET [*2] ##0 s_pri_load
      |=> transmit_receive_status_bit == $past(cmd_word[18])
      && relay_primary[11:8] == 4'h0)
      else $error("dual board status or unused bits wrong");

   a_second_receiver_input_ground: assert property (@(posedge core_clk) disable iff (reset)
      second_receiver_input_ground == relay_secondary[8])
      else $error("ground output disagrees with second word");

   a_dual_bpf: assert property (@(posedge core_clk) disable iff (reset)
      variant == RFCW_DUAL_SET [*2] ##0 s_sec_load
      |=> relay_secondary[6:1] == $past(cmd_word[6:1])
      && relay_secondary[12] == $past(cmd_word[12]))
      else $error("band-pass bits not passed through");

endmodule : rfcw_relay_word

// ---- test/rfcw_board_model.sv ----
// relay board model: coils and changeover as the filter boards see them
// assumes relay words come straight from the control word block
`timescale 1ns/1ps

module rfcw_board_model (
   input wire logic [31:0] relay_primary,
   input wire logic [31:0] relay_secondary,
   output logic [31:0] coil_primary,
   output logic [31:0] coil_secondary,
   output logic tx_path
);
   // ------------------------------------------------------------
   // coil drive
   // ------------------------------------------------------------
   // a set bit energises its relay, a clear bit leaves it at rest
   assign coil_primary = relay_primary;
   assign coil_secondary = relay_secondary;
   // changeover coil on bit 27; energised means transmit path
   assign tx_path = relay_primary[27];
endmodule : rfcw_board_model

// ---- test/tb.sv ----
// testbench for the relay filter control word block
// assumes the design files and the board model are compiled before it
`timescale 1ns/1ps

module tb;
   import rfcw_pkg::*;
   // ------------------------------------------------------------
   // stimulus and observed signals
   // ------------------------------------------------------------
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic cmd_load = 1'b0;
   rfcw_word_sel_t cmd_select = RFCW_SEL_PRIMARY;
   logic [31:0] cmd_word = 32'h0000_0000;
   logic [1:0] variant_pins = 2'h0;
   logic [31:0] relay_primary, relay_secondary, coil_primary, coil_secondary;
   logic transmit_select, transmit_receive_status_bit, second_receiver_input_ground;
   logic command_seen, tx_path;
   int errors = 0;
   int checks_done = 0;
   // connected bits per strap: full, low-pass only, dual set, spare
   logic [31:0] pri_mask [4] = '{32'hFFFC_FF7F, 32'hFFF0_0000, 32'hFFFC_907F, 32'h0000_0000};
   logic [31:0] sec_mask [4] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_917F, 32'h0000_0000};
   // bit 18 set and bit 27 clear, so status and receive both show
   localparam logic [31:0] MIXED = 32'hA5A4_3176;

   rfcw_relay_word uut (.core_clk(core_clk), .reset(reset), .cmd_load(cmd_load),
      .cmd_select(cmd_select), .cmd_word(cmd_word), .variant_pins(variant_pins),
      .relay_primary(relay_primary), .relay_secondary(relay_secondary),
      .transmit_select(transmit_select),
      .transmit_receive_status_bit(transmit_receive_status_bit),
      .second_receiver_input_ground(second_receiver_input_ground),
      .command_seen(command_seen));
   rfcw_board_model board (.relay_primary(relay_primary), .relay_secondary(relay_secondary),
      .coil_primary(coil_primary), .coil_secondary(coil_secondary), .tx_path(tx_path));

   // ------------------------------------------------------------
   // clock, tasks and verdict
   // ------------------------------------------------------------
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   // one edge per call; load held high gives back-to-back commands
   task automatic drive(input logic ld, input rfcw_word_sel_t sel, input logic [31:0] w);
      @(posedge core_clk);
      cmd_load <= ld;
      cmd_select <= sel;
      cmd_word <= w;
   endtask : drive

   // let the answer edge land before sampling
   task automatic settle();
      @(posedge core_clk);
      #1;
   endtask : settle

   task automatic summarize();
      $display("checks_done=%0d errors=%0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize

   // watchdog: the sequence needs under a hundred cycles
   initial begin
      #(400 * 25);
      errors++;
      summarize();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      settle();
      check(relay_primary, 32'h0000_0000);
      check(relay_secondary, 32'h0000_0000);
      check(32'(command_seen), 32'h0000_0000);
      // every strap: both words back to back, then a partial pattern
      for (int v = 0; v < 4; v++) begin
         @(posedge core_clk);
         variant_pins <= v[1:0];
         repeat (4) @(posedge core_clk);
         drive(1'b1, RFCW_SEL_PRIMARY, 32'hFFFF_FFFF);
         drive(1'b1, RFCW_SEL_SECONDARY, 32'hFFFF_FFFF);
         drive(1'b0, RFCW_SEL_PRIMARY, 32'h0000_0000);
         settle();
         check(relay_primary, pri_mask[v]);
         check(coil_primary, pri_mask[v]);
         check(relay_secondary, sec_mask[v]);
         check(32'(transmit_select), 32'h0000_0001);
         check(32'(tx_path), 32'(pri_mask[v][27]));
         check(32'(command_seen), 32'h0000_0001);
         check(32'(second_receiver_input_ground), 32'(sec_mask[v][8]));
         drive(1'b1, RFCW_SEL_PRIMARY, MIXED);
         drive(1'b1, RFCW_SEL_SECONDARY, 32'h0000_0000);
         drive(1'b0, RFCW_SEL_PRIMARY, 32'h0000_0000);
         settle();
         check(relay_primary, MIXED & pri_mask[v]);
         check(coil_secondary, 32'h0000_0000);
         check(32'(transmit_select), 32'h0000_0000);
         check(32'(transmit_receive_status_bit), 32'(v == 2));
      end
      // reset in mid-run clears the word again
      @(posedge core_clk);
      reset <= 1'b1;
      settle();
      check(relay_primary, 32'h0000_0000);
      check(32'(command_seen), 32'h0000_0000);
      check(relay_secondary, 32'h0000_0000);
      check(32'(transmit_select), 32'h0000_0000);
      // release again: words stay clear until a new command
      @(posedge core_clk);
      reset <= 1'b0;
      settle();
      check(relay_primary, 32'h0000_0000);
      check(relay_secondary, 32'h0000_0000);
      summarize();
   end
endmodule : tb
